// *** rtl/mme_mode_entry.sv ***
// mode entry, watchdog rate timer and monitor baud timing
// Contract
// - watchdog period is 10 ms with rate select high and 20 ms with it low.
// - every reset clears the rate select bit so the slow period applies.
// - test voltage and pins 1001 give normal, blank vector forced, else user.
// - in monitor modes the serial link runs at bus clock over 256.
`include "mme_defs.svh"
module mme_mode_entry
  import mme_pkg::*;
#(
  parameter int unsigned WD_FAST_CYC = `MME_WD_FAST_CYC,
  parameter int unsigned WD_SLOW_CYC = `MME_WD_SLOW_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        irq_at_test_voltage,
  input  wire logic        monitor_serial_pin_i,
  input  wire logic        monitor_select_a,
  input  wire logic        monitor_select_b,
  input  wire logic        monitor_select_c,
  input  wire logic [15:0] reset_vector,
  input  wire logic        watchdog_rate_wr,
  input  wire logic        watchdog_rate_wdata,
  input  wire logic        watchdog_kick,
  output logic             watchdog_rate_select,
  output logic             watchdog_timeout,
  output logic [2:0]       mode_onehot,
  output logic             monitor_active,
  output logic             monitor_bit_tick,
  output logic             monitor_sample_tick,
  output logic             monitor_serial_pin_o,
  output logic             monitor_serial_pin_oe
);
  logic        sampled_q;
  mme_mode_t   mode_q;
  logic [31:0] wd_cnt_q;
  logic        bit_tick;
  logic        mid_tick;

  function automatic mme_mode_t pick_mode(input logic tv, input logic p0,
      input logic pa, input logic pb, input logic pc, input logic [15:0] v);
    if (tv && p0 && !pa && !pb && pc)
      return MME_NORMAL;
    else if (v == `MME_BLANK_VECTOR)
      return MME_FORCED;
    else
      return MME_USER;
  endfunction : pick_mode

  // mode capture after reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sampled_q      <= 1'b0;
      mode_q         <= MME_USER;
      mode_onehot    <= 3'b001;
      monitor_active <= 1'b0;
    end else if (clk_en && !sampled_q) begin
      sampled_q      <= 1'b1;
      mode_q         <= pick_mode(irq_at_test_voltage, monitor_serial_pin_i,
                                  monitor_select_a, monitor_select_b,
                                  monitor_select_c, reset_vector);
      mode_onehot    <= pick_mode(irq_at_test_voltage, monitor_serial_pin_i,
                                  monitor_select_a, monitor_select_b,
                                  monitor_select_c, reset_vector);
      monitor_active <= (pick_mode(irq_at_test_voltage, monitor_serial_pin_i,
                                   monitor_select_a, monitor_select_b,
                                   monitor_select_c, reset_vector)
                         != MME_USER);
    end
  end

  // rate select bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_rate_select <= `MME_RATE_RST;
    end else if (clk_en && watchdog_rate_wr) begin
      watchdog_rate_select <= watchdog_rate_wdata;
    end
  end

  // watchdog period counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_q         <= 32'h0000_0000;
      watchdog_timeout <= 1'b0;
    end else if (clk_en) begin
      watchdog_timeout <= 1'b0;
      if (watchdog_kick) begin
        wd_cnt_q <= 32'h0000_0000;
      end else if (wd_cnt_q >= (watchdog_rate_select ? WD_FAST_CYC - 1
                                                     : WD_SLOW_CYC - 1)) begin
        wd_cnt_q         <= 32'h0000_0000;
        watchdog_timeout <= 1'b1;
      end else begin
        wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
      end
    end
  end

  mme_baud_gen u_baud (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .run      (monitor_active),
    .bit_tick (bit_tick),
    .mid_tick (mid_tick)
  );

  // registered baud strobes; pin released, board pull-up holds it high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      monitor_bit_tick      <= 1'b0;
      monitor_sample_tick   <= 1'b0;
      monitor_serial_pin_o  <= 1'b0;
      monitor_serial_pin_oe <= 1'b0;
    end else if (clk_en) begin
      monitor_bit_tick      <= bit_tick;
      monitor_sample_tick   <= mid_tick;
      monitor_serial_pin_o  <= 1'b0;
      monitor_serial_pin_oe <= 1'b0;
    end
  end

  sequence s_released;
    $rose(sampled_q);
  endsequence

  property p_mode_held;
    @(posedge clk_sys) disable iff (!rst_n)
      sampled_q |=> $stable(mode_q);
  endproperty
  a_mode_held: assert property (p_mode_held) else
    $error("mode changed after capture");

  property p_onehot_match;
    @(posedge clk_sys) disable iff (!rst_n)
      sampled_q |-> (mode_onehot == mode_q) &&
                    (monitor_active == (mode_q != MME_USER));
  endproperty
  a_onehot_match: assert property (p_onehot_match) else
    $error("mode outputs disagree");

  property p_wd_bound;
    @(posedge clk_sys) disable iff (!rst_n)
      wd_cnt_q < (watchdog_rate_select ? WD_FAST_CYC : WD_SLOW_CYC)
      || $past(watchdog_rate_wr);
  endproperty
  a_wd_bound: assert property (p_wd_bound) else
    $error("watchdog count beyond period");

  property p_user_quiet;
    @(posedge clk_sys) disable iff (!rst_n)
      s_released ##0 !monitor_active |-> ##2 !monitor_bit_tick [*8];
  endproperty
  a_user_quiet: assert property (p_user_quiet) else
    $error("baud ticks in user mode");

  property p_pin_released;
    @(posedge clk_sys) disable iff (!rst_n)
      !monitor_serial_pin_oe;
  endproperty
  a_pin_released: assert property (p_pin_released) else
    $error("serial pin driven");

  property p_capture_once;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && !sampled_q |=> sampled_q;
  endproperty
  a_capture_once: assert property (p_capture_once) else
    $error("mode capture not taken");

  sequence s_rate_write;
    clk_en && watchdog_rate_wr;
  endsequence

  property p_rate_write;
    @(posedge clk_sys) disable iff (!rst_n)
      s_rate_write |=> watchdog_rate_select == $past(watchdog_rate_wdata);
  endproperty
  a_rate_write: assert property (p_rate_write) else
    $error("rate select write lost");

  property p_rate_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      !(clk_en && watchdog_rate_wr) |=> $stable(watchdog_rate_select);
  endproperty
  a_rate_hold: assert property (p_rate_hold) else
    $error("rate select changed without write");

  sequence s_kick;
    clk_en && watchdog_kick;
  endsequence

  property p_kick_wins;
    @(posedge clk_sys) disable iff (!rst_n)
      s_kick |=> !watchdog_timeout && (wd_cnt_q == 32'h0000_0000);
  endproperty
  a_kick_wins: assert property (p_kick_wins) else
    $error("timeout despite kick");

  property p_timeout_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && watchdog_timeout |=> !watchdog_timeout;
  endproperty
  a_timeout_pulse: assert property (p_timeout_pulse) else
    $error("timeout pulse too long");

  property p_strobe_follow;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && bit_tick |=> monitor_bit_tick;
  endproperty
  a_strobe_follow: assert property (p_strobe_follow) else
    $error("bit strobe not passed on");

  property p_idle_no_strobe;
    @(posedge clk_sys) disable iff (!rst_n)
      !monitor_active |-> !monitor_bit_tick && !monitor_sample_tick;
  endproperty
  a_idle_no_strobe: assert property (p_idle_no_strobe) else
    $error("baud strobe outside monitor modes");
endmodule : mme_mode_entry

// *** shared/mme_defs.svh ***
// constants for monitor mode entry
`ifndef MME_DEFS_SVH
`define MME_DEFS_SVH
`define MME_CLK_MHZ        125
`define MME_WD_FAST_MS     10
`define MME_WD_SLOW_MS     20
`define MME_WD_FAST_CYC    (`MME_WD_FAST_MS * 1000 * `MME_CLK_MHZ)
`define MME_WD_SLOW_CYC    (`MME_WD_SLOW_MS * 1000 * `MME_CLK_MHZ)
`define MME_BLANK_VECTOR   16'hffff
`define MME_BAUD_DIV       256
`define MME_BAUD_HALF      128
`define MME_RATE_RST       1'b0
`endif

// *** shared/mme_pkg.sv ***
// types for monitor mode entry
package mme_pkg;
  typedef enum logic [2:0] {
    MME_USER   = 3'b001,
    MME_NORMAL = 3'b010,
    MME_FORCED = 3'b100
  } mme_mode_t;
endpackage : mme_pkg

// *** rtl/mme_baud_gen.sv ***
// baud tick generator, bus clock divided by 256
`include "mme_defs.svh"
module mme_baud_gen
  import mme_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic run,
  output logic      bit_tick,
  output logic      mid_tick
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 8'h00;
      bit_tick <= 1'b0;
      mid_tick <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_q    <= 8'h00;
        bit_tick <= 1'b0;
        mid_tick <= 1'b0;
      end else begin
        cnt_q    <= cnt_q + 8'h01;
        bit_tick <= (cnt_q == 8'(`MME_BAUD_DIV - 1));
        mid_tick <= (cnt_q == 8'(`MME_BAUD_HALF - 1));
      end
    end
  end

  property p_tick_period;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(bit_tick) && clk_en && run |=> !bit_tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else
    $error("bit tick longer than one cycle");

  property p_tick_at_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && run && (cnt_q == 8'(`MME_BAUD_DIV - 1)) |=> bit_tick;
  endproperty
  a_tick_at_wrap: assert property (p_tick_at_wrap) else
    $error("bit tick missing at counter wrap");
endmodule : mme_baud_gen

// *** bench/mme_host_model.sv ***
// host tool model on the monitor serial pin
module mme_host_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic host_drive_low,
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  // board pull-up unless some driver pulls low
  assign line = ((pin_oe && !pin_o) || host_drive_low) ? 1'b0 : 1'b1;
endmodule : mme_host_model

// *** bench/test_mme_mode_entry.sv ***
// self-checking bench for the mode entry block
module test_mme_mode_entry
  import mme_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_n, clk_en, irq, sa, sb, sc, wr, wd, kick, drv;
  logic [15:0] vec;
  logic [2:0]  mode;
  logic        rate, tmo, act, btick, stick, po, poe, pin_i;
  int          num_errors, checks_done, k, n;
  mme_mode_t   e;
  mme_mode_entry #(.WD_FAST_CYC(10), .WD_SLOW_CYC(20)) i_mme_mode_entry (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .irq_at_test_voltage(irq), .monitor_serial_pin_i(pin_i),
    .monitor_select_a(sa), .monitor_select_b(sb), .monitor_select_c(sc),
    .reset_vector(vec), .watchdog_rate_wr(wr), .watchdog_rate_wdata(wd),
    .watchdog_kick(kick), .watchdog_rate_select(rate),
    .watchdog_timeout(tmo), .mode_onehot(mode), .monitor_active(act),
    .monitor_bit_tick(btick), .monitor_sample_tick(stick),
    .monitor_serial_pin_o(po), .monitor_serial_pin_oe(poe));
  mme_host_model i_mme_host_model (.pin_o(po), .pin_oe(poe),
    .host_drive_low(drv), .line(pin_i));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys; // board oscillator
  end
  function automatic mme_mode_t exp_mode();
    if (irq && !drv && !sa && !sb && sc) return MME_NORMAL;
    return (vec == 16'hffff) ? MME_FORCED : MME_USER;
  endfunction : exp_mode
  task automatic chk(input string what, input logic [15:0] ex, got);
    checks_done++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, ex, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
  endtask : do_reset
  // cycles between two pulses, 0 if none within lim
  task automatic gap(input bit sel, input int lim, output int g);
    int i;
    g = 0;
    for (i = 0; i < lim && (sel ? tmo : btick) !== 1'b1; i++)
      @(negedge clk_sys);
    if (i == lim) return;
    for (g = 1; g < 600; g++) begin
      @(negedge clk_sys);
      if ((sel ? tmo : btick) === 1'b1) return;
    end
    num_errors++;
    end_sim();
  endtask : gap
  // cycles until the chosen pulse shows, 0 if none within lim
  task automatic wait_hi(input int sel, input int lim, output int g);
    int i;
    g = 0;
    for (i = 1; i <= lim; i++) begin
      @(negedge clk_sys);
      if (((sel == 0) ? btick : (sel == 1) ? tmo : stick) === 1'b1) begin
        g = i;
        return;
      end
    end
  endtask : wait_hi
  initial begin
    {rst_n, clk_en, irq, sa, sb, sc, wr, wd, kick, drv} = 10'h100;
    vec = 16'h0000;
    void'($urandom(32'h9c4f));
    @(negedge clk_sys);
    do_reset();
    chk("rate_after_reset", 16'h0000, 16'(rate));
    gap(1, 600, n);
    chk("slow_period", 16'd20, 16'(n));
    wr = 1'b1;
    wd = 1'b1;
    @(negedge clk_sys);
    wr = 1'b0;
    @(negedge clk_sys);
    chk("rate_written", 16'h0001, 16'(rate));
    gap(1, 600, n);
    chk("fast_period", 16'd10, 16'(n));
    repeat (4) @(negedge clk_sys);
    clk_en = 1'b0;
    repeat (6) @(negedge clk_sys);
    chk("frozen_timeout", 16'h0000, 16'(tmo));
    clk_en = 1'b1;
    wait_hi(1, 50, n);
    chk("resumed_period", 16'd6, 16'(n));
    repeat (9) @(negedge clk_sys);
    kick = 1'b1;
    @(negedge clk_sys);
    kick = 1'b0;
    chk("kick_wins", 16'h0000, 16'(tmo));
    wait_hi(1, 50, n);
    chk("kicked_period", 16'd10, 16'(n));
    $display("test watchdog done");
    for (k = 0; k < 12; k++) begin
      {irq, sa, sb, sc, drv} = 5'($urandom);
      vec = (k % 2 == 1) ? 16'hffff : 16'($urandom);
      if (k < 4) {irq, sa, sb, sc, drv} = (k == 3) ? 5'h13 : 5'h12;
      if (k == 1) irq = 1'b0;
      do_reset();
      chk("rate_cleared", 16'h0000, 16'(rate));
      e = exp_mode();
      chk("mode", 16'(e), 16'(mode));
      chk("active", 16'(e != MME_USER), 16'(act));
      {irq, sa, sb, sc, drv} = ~{irq, sa, sb, sc, drv};
      vec = ~vec;
      repeat (2) @(negedge clk_sys);
      chk("mode_held", 16'(e), 16'(mode));
      drv = 1'b0;
      gap(0, 300, n);
      chk("bit_gap", (e == MME_USER) ? 16'd0 : 16'd256, 16'(n));
      wait_hi(2, 300, n);
      chk("sample_lag", (e == MME_USER) ? 16'd0 : 16'd128, 16'(n));
      chk("pin_released", 16'h0000, 16'({po, poe}));
      $display("test mode %0d done", k);
    end
    end_sim();
  end
endmodule : test_mme_mode_entry
